// ==== logic/ncs_ctrl.sv ====
// Frequency, phase and sync control for the two down-converter oscillators.
// Assumes an APB master on pclk and sysref / ILA strobe synchronous to pclk.
`timescale 1ns/1ns
`include "ncs_map.svh"
module ncs_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire ncs_pkg::ncs_word_t pwdata,
  output ncs_pkg::ncs_word_t prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sysref,
  input wire logic ila_lmfc_start,
  input wire ncs_pkg::ncs_sel_t preset_pins_chan_a,
  input wire ncs_pkg::ncs_sel_t preset_pins_chan_b,
  output ncs_pkg::ncs_word_t phase_chan_a,
  output ncs_pkg::ncs_word_t phase_chan_b,
  output logic phase_init_pulse,
  output logic phase_init_armed
);
  import ncs_pkg::*;

  localparam int NP = `NCS_NUM_PRESETS;

  ////////////////////////////////////////////////////////////////////////
  // Register storage
  ncs_word_t freq_word_chan_a_preset_r [NP];
  ncs_word_t freq_word_chan_a_preset_nxt [NP];
  ncs_word_t freq_word_chan_b_preset_r [NP];
  ncs_word_t freq_word_chan_b_preset_nxt [NP];
  ncs_half_t phase_offset_chan_a_preset_r [NP];
  ncs_half_t phase_offset_chan_a_preset_nxt [NP];
  ncs_half_t phase_offset_chan_b_preset_r [NP];
  ncs_half_t phase_offset_chan_b_preset_nxt [NP];
  ncs_half_t rational_ref_divisor_r, rational_ref_divisor_nxt;
  logic [7:0] osc_phase_sync_ctrl_r, osc_phase_sync_ctrl_nxt;
  logic [1:0] preset_source_mode_r, preset_source_mode_nxt;
  ncs_sel_t preset_select_chan_a_r, preset_select_chan_a_nxt;
  ncs_sel_t preset_select_chan_b_r, preset_select_chan_b_nxt;

  // Sync tracking
  logic zero_seen_r, zero_seen_nxt;
  logic armed_r, armed_nxt;
  logic sysref_prev_r;
  logic init_r, init_nxt;

  // Bus answer
  ncs_word_t prdata_r, prdata_nxt;
  logic pready_r, pready_nxt;
  logic pslverr_r, pslverr_nxt;

  logic [9:0] idx;
  logic wr_en;
  logic setup;
  logic sysref_rise;
  ncs_sel_t sel_a, sel_b;

  assign idx = paddr[11:2];
  assign setup = psel & ~penable;
  assign wr_en = psel & penable & pready_r & pwrite & ~pslverr_r;
  assign sysref_rise = sysref & ~sysref_prev_r;

  ////////////////////////////////////////////////////////////////////////
  // Read mux and decode, evaluated in setup so access ends at once
  always_comb begin
    logic hit;
    hit = 1'b1;
    prdata_nxt = 32'h0000_0000;
    if (idx == `NCS_IDX_MODE) begin
      prdata_nxt = {30'h0, preset_source_mode_r};
    end else if (idx == `NCS_IDX_PRESET_SEL) begin
      prdata_nxt = {28'h0, preset_select_chan_b_r, preset_select_chan_a_r};
    end else if (idx == `NCS_IDX_RDIV) begin
      prdata_nxt = {16'h0, rational_ref_divisor_r};
    end else if (idx == `NCS_IDX_SYNC) begin
      prdata_nxt = {24'h0, osc_phase_sync_ctrl_r};
    end else if (idx[9:3] == 7'(`NCS_IDX_FREQ_BASE >> 3)) begin
      prdata_nxt = idx[2] ? freq_word_chan_b_preset_r[idx[1:0]]
                          : freq_word_chan_a_preset_r[idx[1:0]];
    end else if (idx[9:3] == 7'(`NCS_IDX_PHASE_BASE >> 3)) begin
      prdata_nxt = {16'h0, idx[2] ? phase_offset_chan_b_preset_r[idx[1:0]]
                                  : phase_offset_chan_a_preset_r[idx[1:0]]};
    end else if (idx == `NCS_IDX_STATUS) begin
      prdata_nxt = {30'h0, zero_seen_r, armed_r};
    end else if (idx == `NCS_IDX_PHASE_A) begin
      prdata_nxt = phase_chan_a;
    end else if (idx == `NCS_IDX_PHASE_B) begin
      prdata_nxt = phase_chan_b;
    end else begin
      hit = 1'b0;
    end
    if (!setup) begin
      prdata_nxt = prdata_r;
    end
    pready_nxt = setup;
    pslverr_nxt = setup ? ~hit : 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // Register writes at the access edge
  always_comb begin
    freq_word_chan_a_preset_nxt = freq_word_chan_a_preset_r;
    freq_word_chan_b_preset_nxt = freq_word_chan_b_preset_r;
    phase_offset_chan_a_preset_nxt = phase_offset_chan_a_preset_r;
    phase_offset_chan_b_preset_nxt = phase_offset_chan_b_preset_r;
    rational_ref_divisor_nxt = rational_ref_divisor_r;
    osc_phase_sync_ctrl_nxt = osc_phase_sync_ctrl_r;
    preset_source_mode_nxt = preset_source_mode_r;
    preset_select_chan_a_nxt = preset_select_chan_a_r;
    preset_select_chan_b_nxt = preset_select_chan_b_r;
    if (wr_en) begin
      if (idx == `NCS_IDX_MODE) begin
        preset_source_mode_nxt = pwdata[1:0];
      end else if (idx == `NCS_IDX_PRESET_SEL) begin
        preset_select_chan_a_nxt = pwdata[1:0];
        preset_select_chan_b_nxt = pwdata[3:2];
      end else if (idx == `NCS_IDX_RDIV) begin
        rational_ref_divisor_nxt = pwdata[15:0]; // see RL1
      end else if (idx == `NCS_IDX_SYNC) begin
        osc_phase_sync_ctrl_nxt = pwdata[7:0]; // see RL7
      end else if (idx[9:3] == 7'(`NCS_IDX_FREQ_BASE >> 3)) begin
        // Live changes leave phase undetermined until the link restarts
        if (idx[2]) begin
          freq_word_chan_b_preset_nxt[idx[1:0]] = pwdata; // see RL8
        end else begin
          freq_word_chan_a_preset_nxt[idx[1:0]] = pwdata; // see RL8
        end
      end else if (idx[9:3] == 7'(`NCS_IDX_PHASE_BASE >> 3)) begin
        if (idx[2]) begin
          phase_offset_chan_b_preset_nxt[idx[1:0]] = pwdata[15:0];
        end else begin
          phase_offset_chan_a_preset_nxt[idx[1:0]] = pwdata[15:0];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Arming and phase init; a fresh arm wins over a same-cycle SYSREF edge
  always_comb begin
    logic arm_wr;
    arm_wr = wr_en && idx == `NCS_IDX_SYNC;
    zero_seen_nxt = zero_seen_r;
    armed_nxt = armed_r;
    init_nxt = 1'b0;
    if (armed_r && sysref_rise) begin
      armed_nxt = 1'b0; // see RL4
      init_nxt = 1'b1; // see RL3
    end
    if (osc_phase_sync_ctrl_r[`NCS_SYNC_ILA_BIT] && ila_lmfc_start) begin
      init_nxt = 1'b1; // see RL2
    end
    if (arm_wr) begin
      if (!pwdata[`NCS_SYNC_NEXT_BIT]) begin
        zero_seen_nxt = 1'b1;
        armed_nxt = 1'b0;
      end else if (zero_seen_r) begin
        zero_seen_nxt = 1'b0;
        armed_nxt = 1'b1; // see RL3
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Active preset per channel
  always_comb begin
    sel_a = preset_select_chan_a_r; // see RL11
    sel_b = preset_select_chan_b_r;
    case (ncs_src_e'(preset_source_mode_r))
      NCS_SRC_PINS_EACH: begin
        sel_a = preset_pins_chan_a;
        sel_b = preset_pins_chan_b;
      end
      NCS_SRC_PIN_A_BOTH: begin
        sel_a = preset_pins_chan_a;
        sel_b = preset_pins_chan_a;
      end
      default: begin
        sel_a = preset_select_chan_a_r;
        sel_b = preset_select_chan_b_r;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // State registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NP; i++) begin
        freq_word_chan_a_preset_r[i] <= `NCS_FREQ_RESET;
        freq_word_chan_b_preset_r[i] <= `NCS_FREQ_RESET;
        phase_offset_chan_a_preset_r[i] <= `NCS_PHASE_RESET;
        phase_offset_chan_b_preset_r[i] <= `NCS_PHASE_RESET;
      end
      rational_ref_divisor_r <= `NCS_RDIV_RESET;
      osc_phase_sync_ctrl_r <= `NCS_SYNC_RESET; // see RL7
      preset_source_mode_r <= `NCS_MODE_RESET;
      preset_select_chan_a_r <= 2'(`NCS_SEL_RESET);
      preset_select_chan_b_r <= 2'(`NCS_SEL_RESET >> 2);
      zero_seen_r <= 1'b0;
      armed_r <= 1'b0;
      sysref_prev_r <= 1'b0;
      init_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      freq_word_chan_a_preset_r <= freq_word_chan_a_preset_nxt;
      freq_word_chan_b_preset_r <= freq_word_chan_b_preset_nxt;
      phase_offset_chan_a_preset_r <= phase_offset_chan_a_preset_nxt;
      phase_offset_chan_b_preset_r <= phase_offset_chan_b_preset_nxt;
      rational_ref_divisor_r <= rational_ref_divisor_nxt;
      osc_phase_sync_ctrl_r <= osc_phase_sync_ctrl_nxt;
      preset_source_mode_r <= preset_source_mode_nxt;
      preset_select_chan_a_r <= preset_select_chan_a_nxt;
      preset_select_chan_b_r <= preset_select_chan_b_nxt;
      zero_seen_r <= zero_seen_nxt;
      armed_r <= armed_nxt;
      sysref_prev_r <= sysref;
      init_r <= init_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Accumulators; the shared divisor feeds both channels
  ncs_acc_if acc_a ();
  ncs_acc_if acc_b ();

  assign acc_a.freq = freq_word_chan_a_preset_r[sel_a];
  assign acc_a.phase_off = phase_offset_chan_a_preset_r[sel_a];
  assign acc_a.rdiv = rational_ref_divisor_r; // see RL1
  assign acc_a.init = init_r;
  assign acc_b.freq = freq_word_chan_b_preset_r[sel_b];
  assign acc_b.phase_off = phase_offset_chan_b_preset_r[sel_b];
  assign acc_b.rdiv = rational_ref_divisor_r;
  assign acc_b.init = init_r;

  ncs_phase_acc u_acc_a (
    .pclk(pclk),
    .presetn(presetn),
    .bus(acc_a.acc)
  );

  ncs_phase_acc u_acc_b (
    .pclk(pclk),
    .presetn(presetn),
    .bus(acc_b.acc)
  );

  // All outputs come from flip-flops
  assign phase_chan_a = acc_a.phase;
  assign phase_chan_b = acc_b.phase;
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign phase_init_pulse = init_r;
  assign phase_init_armed = armed_r;
endmodule

// ==== logic/ncs_map.svh ====
// Register indices, field positions, reset values and preset count
// for the oscillator frequency and phase sync control block.
// Assumes an APB slave where byte address equals four times the index.
//
// Overview of operation
// RL1 - One shared 16-bit divisor trims frequency error
// RL2 - Align-sequence bit set: init phase at ILA LMFC
// RL3 - Arm bit written 0 then 1: next SYSREF inits
// RL4 - After SYSREF init, ignore SYSREF until re-armed
// RL5 - Controller powers device, enables link, runs clock first
// RL6 - Controller idles SYSREF, clears ILA bit, arms, pulses
// RL7 - Sync control at 0x219, resets to 0x02
// RL8 - Separate 32-bit word per channel and preset
// RL9 - Software re-initialises link after live frequency change
// RL10 - Frequency word works signed or unsigned
// RL11 - Mode 0: per-channel register fields pick preset
// RL12 - 16-bit phase offset MSB-justified, added to accumulator
// RL13 - Accumulator adds frequency word each clock, wraps
// RL14 - Phase init clears accumulator before offset
`ifndef NCS_MAP_SVH
`define NCS_MAP_SVH

`define NCS_IDX_MODE 10'h214
`define NCS_IDX_PRESET_SEL 10'h215
`define NCS_IDX_RDIV 10'h217
`define NCS_IDX_SYNC 10'h219
`define NCS_IDX_FREQ_BASE 10'h220
`define NCS_IDX_PHASE_BASE 10'h228
`define NCS_IDX_STATUS 10'h230
`define NCS_IDX_PHASE_A 10'h231
`define NCS_IDX_PHASE_B 10'h232

`define NCS_SYNC_NEXT_BIT 0
`define NCS_SYNC_ILA_BIT 1
`define NCS_SYNC_RESET 8'h02
`define NCS_MODE_RESET 2'h0
`define NCS_SEL_RESET 4'h0
`define NCS_RDIV_RESET 16'h0000
`define NCS_FREQ_RESET 32'hc000_0000
`define NCS_PHASE_RESET 16'h0000
`define NCS_NUM_PRESETS 4

`endif

// ==== logic/ncs_pkg.sv ====
// Types shared by the oscillator sync control block and its accumulators.
// Assumes nothing beyond a SystemVerilog tool.
package ncs_pkg;
  typedef logic [31:0] ncs_word_t;
  typedef logic [15:0] ncs_half_t;
  typedef logic [1:0] ncs_sel_t;
  // Preset source, in the order of its 2-bit code
  typedef enum logic [1:0] {
    NCS_SRC_REGS,
    NCS_SRC_PINS_EACH,
    NCS_SRC_PIN_A_BOTH,
    NCS_SRC_RESERVED
  } ncs_src_e;
endpackage

// ==== logic/ncs_acc_if.sv ====
// Bundle between the control block and one phase accumulator.
// Assumes both ends share pclk.
`timescale 1ns/1ns
interface ncs_acc_if;
  import ncs_pkg::*;
  ncs_word_t freq;
  ncs_half_t phase_off;
  ncs_half_t rdiv;
  logic init;
  ncs_word_t phase;
  modport ctrl (output freq, output phase_off, output rdiv, output init, input phase);
  modport acc (input freq, input phase_off, input rdiv, input init, output phase);
endinterface

// ==== logic/ncs_phase_acc.sv ====
// One channel's phase accumulator with rational trim and phase offset.
// Assumes the controller holds freq, offset and divisor steady per cycle.
`timescale 1ns/1ns
module ncs_phase_acc (
  input wire logic pclk,
  input wire logic presetn,
  ncs_acc_if.acc bus
);
  import ncs_pkg::*;

  ncs_word_t acc_r, acc_nxt;
  ncs_word_t out_r, out_nxt;
  ncs_half_t trim_r, trim_nxt;

  ////////////////////////////////////////////////////////////////////////
  // Next accumulator value; trim adds one LSB per divisor period
  always_comb begin
    ncs_word_t step;
    step = bus.freq;
    trim_nxt = trim_r;
    if (bus.rdiv != 16'h0000) begin
      // A zero divisor turns the trim off rather than dividing by zero
      if (trim_r >= bus.rdiv - 16'h0001) begin
        trim_nxt = 16'h0000;
        step = bus.freq + 32'h0000_0001; // see RL1
      end else begin
        trim_nxt = trim_r + 16'h0001;
      end
    end
    if (bus.init) begin
      acc_nxt = 32'h0000_0000; // see RL14
      trim_nxt = 16'h0000;
    end else begin
      acc_nxt = acc_r + step; // see RL13, RL10
    end
    out_nxt = acc_nxt + {bus.phase_off, 16'h0000}; // see RL12
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_r <= 32'h0000_0000;
      out_r <= 32'h0000_0000;
      trim_r <= 16'h0000;
    end else begin
      acc_r <= acc_nxt;
      out_r <= out_nxt;
      trim_r <= trim_nxt;
    end
  end

  assign bus.phase = out_r;
endmodule

// ==== verif/ncs_ctrl_monitor.sv ====
// Port checker for the oscillator frequency and phase sync control block.
// Assumes a bind onto ncs_ctrl; the sync register is shadowed from APB writes.
`timescale 1ns/1ns
`include "ncs_map.svh"
module ncs_ctrl_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire ncs_pkg::ncs_word_t pwdata,
  input wire ncs_pkg::ncs_word_t prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic sysref,
  input wire logic ila_lmfc_start,
  input wire ncs_pkg::ncs_sel_t preset_pins_chan_a,
  input wire ncs_pkg::ncs_sel_t preset_pins_chan_b,
  input wire ncs_pkg::ncs_word_t phase_chan_a,
  input wire ncs_pkg::ncs_word_t phase_chan_b,
  input wire logic phase_init_pulse,
  input wire logic phase_init_armed
);
  import ncs_pkg::*;
  logic wr_sync;
  logic [7:0] sync_r;
  logic zero_r;
  default clocking mon_cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////
  // Shadow copy, since the register itself is hidden from the ports
  assign wr_sync = psel & penable & pready & pwrite & (paddr[11:2] == `NCS_IDX_SYNC);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_r <= `NCS_SYNC_RESET;
      zero_r <= 1'b0;
    end else if (wr_sync) begin
      sync_r <= pwdata[7:0];
      zero_r <= ~pwdata[0]; // Arming needs the zero write first
    end
  end
  ////////////////////////////////////////
  AST_READY_AFTER_SETUP: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  AST_READY_IN_ACCESS: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  AST_ERR_WITH_READY: assert property (pslverr |-> pready)
    else $error("error without ready");
  AST_ILA_INIT: assert property (ila_lmfc_start && sync_r[1] |=> phase_init_pulse)
    else $error("no init on align sequence");
  AST_NO_STRAY_INIT: assert property (phase_init_pulse |-> $past(ila_lmfc_start && sync_r[1])
    || ($past(phase_init_armed) && $past(sysref) && !$past(sysref, 2)))
    else $error("init without cause");
  AST_SYSREF_INIT: assert property (phase_init_armed && $rose(sysref) && !wr_sync
    |=> phase_init_pulse && !phase_init_armed)
    else $error("armed edge did not init");
  AST_ARM_SET: assert property (wr_sync && pwdata[0] && zero_r |=> phase_init_armed)
    else $error("zero then one did not arm");
  AST_ARM_CLEAR: assert property (wr_sync && !pwdata[0] |=> !phase_init_armed)
    else $error("zero write left arm");
  AST_NO_SELF_ARM: assert property ($rose(phase_init_armed) |-> $past(wr_sync && zero_r))
    else $error("arm without zero then one");
endmodule

// ==== verif/ncs_ctrl_tb_top.sv ====
// Self-checking bench for the oscillator frequency and phase sync control.
// Assumes ncs_ctrl with a zero-wait APB slave and a 125 MHz pclk.
`timescale 1ns/1ns
`include "ncs_map.svh"
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin num_errors++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module ncs_ctrl_tb_top;
  import ncs_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, sysref, ila_lmfc_start;
  logic pready, pslverr, phase_init_pulse, phase_init_armed, erv;
  logic [11:0] paddr;
  ncs_word_t pwdata, prdata, phase_chan_a, phase_chan_b, rdv, da, db;
  ncs_sel_t preset_pins_chan_a, preset_pins_chan_b;
  ncs_word_t freq_m [8];
  ncs_half_t off_m [8];
  int num_errors = 0;
  int comparisons = 0;
  int r;
  integer seed = 32'h012868f2;
  ncs_ctrl u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .sysref, .ila_lmfc_start, .preset_pins_chan_a, .preset_pins_chan_b,
    .phase_chan_a, .phase_chan_b, .phase_init_pulse, .phase_init_armed);
  ////////////////////////////////////////
  // Clock and hang guard
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  initial begin
    repeat (5000) @(posedge pclk);
    num_errors++;
    finish_test();
  end
  task automatic finish_test;
    $display("comparisons=%0d num_errors=%0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // One APB transfer; request held until pready is sampled high at a rising edge
  task automatic apb(input logic wr, input logic [9:0] idx, input ncs_word_t wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // No wait count assumed; only the watchdog ends a hung access
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdv = prdata;
    erv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Phase advance over n cycles on both channels
  task automatic span(input int n);
    ncs_word_t a0, b0;
    // One edge first, so a setting changed at the calling edge is in both samples
    @(posedge pclk);
    @(negedge pclk);
    a0 = phase_chan_a;
    b0 = phase_chan_b;
    repeat (n) @(negedge pclk);
    da = phase_chan_a - a0;
    db = phase_chan_b - b0;
  endtask
  // One-cycle sync cause, then pulse and restarted phase are checked
  task automatic fire(input logic use_sr, input logic exp);
    @(posedge pclk);
    if (use_sr) sysref <= 1'b1;
    else ila_lmfc_start <= 1'b1;
    @(posedge pclk);
    sysref <= 1'b0;
    ila_lmfc_start <= 1'b0;
    @(negedge pclk);
    `CHK(phase_init_pulse, exp)
    @(negedge pclk);
    if (exp) begin
      `CHK(phase_chan_a, {off_m[1], 16'h0})
      `CHK(phase_chan_b, {off_m[6], 16'h0})
    end
  endtask
  function automatic ncs_sel_t pick(input int m, input ncs_sel_t rs, ps, pa);
    case (m)
      1: return ps;
      2: return pa;
      default: return rs;
    endcase
  endfunction
  ////////////////////////////////////////
  initial begin
    {presetn, psel, penable, pwrite, sysref, ila_lmfc_start} = '0;
    {paddr, pwdata, preset_pins_chan_a, preset_pins_chan_b} = '0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, `NCS_IDX_SYNC, 0);
    `CHK(rdv, 32'h0000_0002)
    apb(0, `NCS_IDX_RDIV, 0);
    `CHK(rdv, 32'h0)
    apb(0, 10'h3ff, 0);
    `CHK({erv, rdv}, 33'h1_0000_0000)
    // Every word starts at reset, then takes a value of its own
    for (int i = 0; i < 8; i++) begin
      apb(0, 10'(`NCS_IDX_FREQ_BASE + i), 0);
      `CHK(rdv, 32'hc000_0000)
      freq_m[i] = (i == 0) ? 32'h8000_0000 : $random(seed);
      off_m[i] = 16'($random(seed));
      apb(1, 10'(`NCS_IDX_FREQ_BASE + i), freq_m[i]);
      apb(1, 10'(`NCS_IDX_PHASE_BASE + i), {16'h0, off_m[i]});
    end
    for (int i = 0; i < 8; i++) begin
      apb(0, 10'(`NCS_IDX_FREQ_BASE + i), 0);
      `CHK(rdv, freq_m[i])
    end
    // All preset sources, register selects walked, pins random
    for (int m = 0; m < 4; m++) begin
      for (int k = 0; k < 4; k++) begin
        apb(1, `NCS_IDX_MODE, 32'(m));
        apb(1, `NCS_IDX_PRESET_SEL, {28'h0, 2'(k + 1), 2'(k)});
        preset_pins_chan_a <= 2'($random(seed));
        preset_pins_chan_b <= 2'($random(seed));
        span(1);
        r = pick(m, 2'(k), preset_pins_chan_a, preset_pins_chan_a);
        `CHK(da, freq_m[r])
        r = 4 + pick(m, 2'(k + 1), preset_pins_chan_b, preset_pins_chan_a);
        `CHK(db, freq_m[r])
      end
    end
    apb(1, `NCS_IDX_MODE, 0);
    apb(1, `NCS_IDX_PRESET_SEL, 32'h9);
    // Divisor adds one LSB every r cycles on both channels
    r = 2 + ($unsigned($random(seed)) % 6);
    apb(1, `NCS_IDX_RDIV, 32'(r));
    repeat (2 * r) @(posedge pclk);
    span(3 * r);
    `CHK(da, ncs_word_t'(3 * r * freq_m[1] + 3))
    `CHK(db, ncs_word_t'(3 * r * freq_m[6] + 3))
    // Sync sequences: unarmed edge, align sequence, arm and one-shot
    apb(1, `NCS_IDX_SYNC, 32'h3);
    @(negedge pclk);
    `CHK(phase_init_armed, 1'b0)
    fire(1, 1'b0);
    fire(0, 1'b1);
    apb(1, `NCS_IDX_SYNC, 32'h0);
    fire(0, 1'b0);
    apb(1, `NCS_IDX_SYNC, 32'h1);
    @(negedge pclk);
    `CHK(phase_init_armed, 1'b1)
    apb(0, `NCS_IDX_STATUS, 0);
    `CHK(rdv, 32'h0000_0001)
    fire(1, 1'b1);
    `CHK(phase_init_armed, 1'b0)
    fire(1, 1'b0);
    apb(1, `NCS_IDX_SYNC, 32'h0);
    apb(1, `NCS_IDX_SYNC, 32'h1);
    fire(1, 1'b1);
    finish_test();
  end
endmodule
bind ncs_ctrl ncs_ctrl_monitor u_mon (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .sysref, .ila_lmfc_start, .preset_pins_chan_a,
  .preset_pins_chan_b, .phase_chan_a, .phase_chan_b, .phase_init_pulse, .phase_init_armed);
